/* File: src/phy_base_regs_map.svh */
// register indices, field positions, reset values and timing counts of the phy base register bank
// What this block does
// - read-only six-bit node identity, loaded during self-id
// - identity 63 means misconfigured; link sends nothing
// - read-only root flag, reads one when root
// - cable power flag follows threshold, powers up one
// - root hold-off bit forces root attempt next
// - bus reset request runs full reset, self-clears
// - six-bit gap count, resets all ones, drives arbitration
// - map type field always reads seven
// - port count field reads three
// - speed capability field reads 010
// - repeater delay field reads zero
// - link-active bit ANDed with link power status on the self-id output
// - contender bit, power-on value from strap
// - jitter field reads zero
// - power class bits, power-on value from straps
// - fields packed into five eight-bit registers
`ifndef PHY_BASE_REGS_MAP_SVH
`define PHY_BASE_REGS_MAP_SVH

// register indices; byte address is four times the index
`define IDX_NODE_IDENTITY_STATUS  3'h0
`define IDX_RESET_AND_GAP_CONTROL 3'h1
`define IDX_MAP_TYPE_PORT_COUNT   3'h2
`define IDX_SPEED_AND_DELAY       3'h3
`define IDX_SELF_ID_CONTROL       3'h4
`define IDX_LAST                  3'h4

// field positions
`define POS_NODE_ID   2
`define POS_ROOT      1
`define POS_CABLE_PWR 0
`define POS_HOLD_OFF  7
`define POS_BUS_RST   6
`define POS_GAP       0
`define POS_MAP_TYPE  5
`define POS_PORTS     0
`define POS_SPEED     5
`define POS_DELAY     0
`define POS_LINK_ACT  7
`define POS_CONTENDER 6
`define POS_JITTER    3
`define POS_PWR_CLASS 0

// reset and constant values
`define RST_NODE_ID      6'h00
`define MISCONFIG_ID     6'h3f
`define RST_ROOT         1'h0
`define RST_CABLE_PWR    1'h1
`define RST_HOLD_OFF     1'h0
`define RST_BUS_RST      1'h0
`define RST_GAP          6'h3f
`define VAL_MAP_TYPE     3'h7
`define VAL_PORTS        4'h3
`define VAL_SPEED        3'h2
`define VAL_DELAY        4'h0
`define RST_LINK_ACT     1'h1
`define VAL_JITTER       3'h0

// timing
`define CLK_PERIOD_NS    100
`define BUS_RESET_NS     166000
`define BUS_RESET_CYCLES ((`BUS_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: src/phy_base_regs_pkg.sv */
// types shared by the phy base register bank modules
`default_nettype none
package phy_base_regs_pkg;
  typedef enum logic [0:0] {
    RST_IDLE   = 1'b0,
    RST_DRIVE  = 1'b1
  } bus_reset_state_t;
  typedef enum logic [0:0] {
    STRAP_WAIT = 1'b0,
    STRAP_DONE = 1'b1
  } strap_state_t;
  typedef logic [7:0]  phy_reg_t;
  typedef logic [10:0] reset_count_t;
endpackage : phy_base_regs_pkg
`default_nettype wire

/* File: src/phy_ctrl_if.sv */
// links the register bank to its bus-reset timer and strap capture
`default_nettype none
interface phy_ctrl_if;
  logic       resetStart;
  logic       resetBusy;
  logic       resetDrive;
  logic       strapLoad;
  logic       strapContender;
  logic [2:0] strapPowerClass;
  modport timer     (input resetStart, output resetBusy, output resetDrive);
  modport timerUser (output resetStart, input resetBusy, input resetDrive);
  modport strap     (output strapLoad, output strapContender, output strapPowerClass);
  modport strapUser (input strapLoad, input strapContender, input strapPowerClass);
endinterface : phy_ctrl_if
`default_nettype wire

/* File: src/bus_reset_timer.sv */
// holds the unarbitrated bus reset signal for the full reset time
`include "phy_base_regs_map.svh"
`default_nettype none
module bus_reset_timer
  import phy_base_regs_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst_n,
  phy_ctrl_if.timer     ctrl
);
  localparam reset_count_t RESET_LAST = reset_count_t'(`BUS_RESET_CYCLES - 1);

  bus_reset_state_t stateReg;
  bus_reset_state_t stateNext;
  reset_count_t     countReg;
  reset_count_t     countNext;

  always_comb begin
    stateNext = stateReg;
    countNext = countReg;
    case (stateReg)
      RST_IDLE: begin
        if (ctrl.resetStart) begin
          stateNext = RST_DRIVE;
          countNext = '0;
        end
      end
      RST_DRIVE: begin
        if (countReg == RESET_LAST) begin
          stateNext = RST_IDLE;
        end else begin
          countNext = countReg + reset_count_t'(1);
        end
      end
      default: stateNext = RST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= RST_IDLE;
      countReg <= '0;
    end else begin
      stateReg <= stateNext;
      countReg <= countNext;
    end
  end

  assign ctrl.resetDrive = (stateReg == RST_DRIVE);
  assign ctrl.resetBusy  = (stateReg == RST_DRIVE);
endmodule : bus_reset_timer
`default_nettype wire

/* File: src/strap_capture.sv */
// samples the contender and power-class straps once after reset release
`include "phy_base_regs_map.svh"
`default_nettype none
module strap_capture
  import phy_base_regs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       contenderStrap,
  input  wire logic [2:0] powerClassStrap,
  phy_ctrl_if.strap       ctrl
);
  strap_state_t stateReg;
  strap_state_t stateNext;
  logic         contenderReg;
  logic         contenderNext;
  logic [2:0]   powerClassReg;
  logic [2:0]   powerClassNext;
  logic         loadReg;
  logic         loadNext;

  // async reset may only load constants, so pins are caught on the first edge after release
  always_comb begin
    stateNext      = stateReg;
    contenderNext  = contenderReg;
    powerClassNext = powerClassReg;
    loadNext       = 1'b0;
    case (stateReg)
      STRAP_WAIT: begin
        stateNext      = STRAP_DONE;
        contenderNext  = contenderStrap;
        powerClassNext = powerClassStrap;
        loadNext       = 1'b1;
      end
      STRAP_DONE: stateNext = STRAP_DONE;
      default:    stateNext = STRAP_WAIT;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg      <= STRAP_WAIT;
      contenderReg  <= 1'b0;
      powerClassReg <= 3'h0;
      loadReg       <= 1'b0;
    end else begin
      stateReg      <= stateNext;
      contenderReg  <= contenderNext;
      powerClassReg <= powerClassNext;
      loadReg       <= loadNext;
    end
  end

  assign ctrl.strapLoad       = loadReg;
  assign ctrl.strapContender  = contenderReg;
  assign ctrl.strapPowerClass = powerClassReg;
endmodule : strap_capture
`default_nettype wire

/* File: src/phy_core_base_registers.sv */
// phy base register bank on apb with self-id control outputs
`include "phy_base_regs_map.svh"
`default_nettype none
module phy_core_base_registers
  import phy_base_regs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // phy core status inputs
  input  wire logic        nodeIdLoad,
  input  wire logic [5:0]  nodeIdIn,
  input  wire logic        rootIn,
  input  wire logic        cablePowerOk,
  input  wire logic        linkPowerActive,
  input  wire logic        contenderStrap,
  input  wire logic [2:0]  powerClassStrap,
  // phy core control outputs
  output logic             forceRoot,
  output logic             busResetDrive,
  output logic [5:0]       gapCount,
  output logic             linkTxInhibit,
  output logic             selfIdLinkActive,
  output logic             selfIdContender,
  output logic [2:0]       selfIdPowerClass
);
  phy_ctrl_if ctrl ();

  bus_reset_timer u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .ctrl  (ctrl.timer)
  );

  strap_capture u_strap (
    .clk             (clk),
    .rst_n           (rst_n),
    .contenderStrap  (contenderStrap),
    .powerClassStrap (powerClassStrap),
    .ctrl            (ctrl.strap)
  );

  // ---- apb decode
  logic       preadyReg;
  logic       preadyNext;
  logic       setupPhase;
  logic       accessPhase;
  logic       wordAligned;
  logic [2:0] regIndex;
  logic       indexValid;
  logic       writeLane0;
  logic       regWrite;
  logic       wrResetGap;
  logic       wrSelfId;

  assign setupPhase  = psel && !penable;
  // a write lands only at the edge where the master samples pready high
  assign accessPhase = psel && penable && preadyReg;
  assign wordAligned = (paddr[1:0] == 2'b00) && (paddr[11:5] == 7'h00);
  assign regIndex    = paddr[4:2];
  assign indexValid  = wordAligned && (regIndex <= `IDX_LAST);
  assign writeLane0  = pstrb[0];
  assign regWrite    = accessPhase && pwrite && indexValid && writeLane0;
  // identity, root, power, map, speed and delay have no write path at all
  assign wrResetGap  = regWrite && (regIndex == `IDX_RESET_AND_GAP_CONTROL);
  assign wrSelfId    = regWrite && (regIndex == `IDX_SELF_ID_CONTROL);

  // ---- status group: identity, root and cable power follow the core
  logic [5:0] nodeIdReg;
  logic [5:0] nodeIdNext;
  logic       rootReg;
  logic       rootNext;
  logic       cablePwrReg;
  logic       cablePwrNext;

  always_comb begin
    nodeIdNext   = nodeIdReg;
    rootNext     = rootIn;
    cablePwrNext = cablePowerOk;
    if (nodeIdLoad) begin
      nodeIdNext = nodeIdIn;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nodeIdReg   <= `RST_NODE_ID;
      rootReg     <= `RST_ROOT;
      cablePwrReg <= `RST_CABLE_PWR;
    end else begin
      nodeIdReg   <= nodeIdNext;
      rootReg     <= rootNext;
      cablePwrReg <= cablePwrNext;
    end
  end

  // ---- control group: root hold-off, bus reset request, gap count
  logic       holdOffReg;
  logic       holdOffNext;
  logic       busRstReqReg;
  logic       busRstReqNext;
  logic [5:0] gapReg;
  logic [5:0] gapNext;

  always_comb begin
    holdOffNext   = holdOffReg;
    busRstReqNext = busRstReqReg;
    gapNext       = gapReg;
    // the request bit stays visible for one cycle, then clears itself whether or not the timer takes it
    if (busRstReqReg) begin
      busRstReqNext = 1'b0;
    end
    // a new request in the clearing cycle wins over the self-clear
    if (wrResetGap) begin
      holdOffNext = pwdata[`POS_HOLD_OFF];
      gapNext     = pwdata[`POS_GAP +: 6];
      if (pwdata[`POS_BUS_RST]) begin
        busRstReqNext = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      holdOffReg   <= `RST_HOLD_OFF;
      busRstReqReg <= `RST_BUS_RST;
      gapReg       <= `RST_GAP;
    end else begin
      holdOffReg   <= holdOffNext;
      busRstReqReg <= busRstReqNext;
      gapReg       <= gapNext;
    end
  end

  // ---- self-id group: link active, contender and power class
  logic       linkActReg;
  logic       linkActNext;
  logic       contenderReg;
  logic       contenderNext;
  logic [2:0] pwrClassReg;
  logic [2:0] pwrClassNext;

  always_comb begin
    linkActNext   = linkActReg;
    contenderNext = contenderReg;
    pwrClassNext  = pwrClassReg;
    if (ctrl.strapLoad) begin
      contenderNext = ctrl.strapContender;
      pwrClassNext  = ctrl.strapPowerClass;
    end
    if (wrSelfId) begin
      linkActNext   = pwdata[`POS_LINK_ACT];
      contenderNext = pwdata[`POS_CONTENDER];
      pwrClassNext  = pwdata[`POS_PWR_CLASS +: 3];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linkActReg   <= `RST_LINK_ACT;
      contenderReg <= 1'b0;
      pwrClassReg  <= 3'h0;
    end else begin
      linkActReg   <= linkActNext;
      contenderReg <= contenderNext;
      pwrClassReg  <= pwrClassNext;
    end
  end

  // a request while a reset is already being driven is absorbed by the running one
  assign ctrl.resetStart = busRstReqReg && !ctrl.resetBusy;

  // ---- read mux
  phy_reg_t statusByte;
  phy_reg_t controlByte;
  phy_reg_t mapByte;
  phy_reg_t speedByte;
  phy_reg_t selfIdByte;
  phy_reg_t readByte;

  // every register image starts from zero so unused positions read zero
  always_comb begin
    statusByte                      = 8'h00;
    controlByte                     = 8'h00;
    mapByte                         = 8'h00;
    speedByte                       = 8'h00;
    selfIdByte                      = 8'h00;
    statusByte[`POS_NODE_ID +: 6]   = nodeIdReg;
    statusByte[`POS_ROOT]           = rootReg;
    statusByte[`POS_CABLE_PWR]      = cablePwrReg;
    controlByte[`POS_HOLD_OFF]      = holdOffReg;
    controlByte[`POS_BUS_RST]       = busRstReqReg;
    controlByte[`POS_GAP +: 6]      = gapReg;
    mapByte[`POS_MAP_TYPE +: 3]     = `VAL_MAP_TYPE;
    mapByte[`POS_PORTS +: 4]        = `VAL_PORTS;
    speedByte[`POS_SPEED +: 3]      = `VAL_SPEED;
    speedByte[`POS_DELAY +: 4]      = `VAL_DELAY;
    selfIdByte[`POS_LINK_ACT]       = linkActReg;
    selfIdByte[`POS_CONTENDER]      = contenderReg;
    selfIdByte[`POS_JITTER +: 3]    = `VAL_JITTER;
    selfIdByte[`POS_PWR_CLASS +: 3] = pwrClassReg;
  end

  always_comb begin
    readByte = 8'h00;
    if (regIndex == `IDX_NODE_IDENTITY_STATUS) begin
      readByte = statusByte;
    end else if (regIndex == `IDX_RESET_AND_GAP_CONTROL) begin
      readByte = controlByte;
    end else if (regIndex == `IDX_MAP_TYPE_PORT_COUNT) begin
      readByte = mapByte;
    end else if (regIndex == `IDX_SPEED_AND_DELAY) begin
      readByte = speedByte;
    end else if (regIndex == `IDX_SELF_ID_CONTROL) begin
      readByte = selfIdByte;
    end
  end

  // ---- apb answer, one access cycle, no wait states
  logic [31:0] prdataReg;
  logic [31:0] prdataNext;
  logic        pslverrReg;
  logic        pslverrNext;

  always_comb begin
    preadyNext  = 1'b0;
    prdataNext  = 32'h0000_0000;
    pslverrNext = 1'b0;
    if (setupPhase) begin
      preadyNext  = 1'b1;
      pslverrNext = !indexValid;
      if (!pwrite && indexValid) begin
        prdataNext = {24'h00_0000, readByte};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preadyReg  <= 1'b0;
      prdataReg  <= 32'h0000_0000;
      pslverrReg <= 1'b0;
    end else begin
      preadyReg  <= preadyNext;
      prdataReg  <= prdataNext;
      pslverrReg <= pslverrNext;
    end
  end

  // ---- registered control outputs
  logic       busRstOutReg;
  logic       busRstOutNext;
  logic       inhibitReg;
  logic       inhibitNext;
  logic       selfIdLinkReg;
  logic       selfIdLinkNext;

  // one flop after the timer so the pin never glitches on a state change
  always_comb begin
    busRstOutNext  = ctrl.resetDrive;
    inhibitNext    = (nodeIdReg == `MISCONFIG_ID);
    selfIdLinkNext = linkActReg && linkPowerActive;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busRstOutReg  <= 1'b0;
      inhibitReg    <= 1'b0;
      selfIdLinkReg <= 1'b0;
    end else begin
      busRstOutReg  <= busRstOutNext;
      inhibitReg    <= inhibitNext;
      selfIdLinkReg <= selfIdLinkNext;
    end
  end

  assign pready           = preadyReg;
  assign prdata           = prdataReg;
  assign pslverr          = pslverrReg;
  assign forceRoot        = holdOffReg;
  assign busResetDrive    = busRstOutReg;
  assign gapCount         = gapReg;
  assign linkTxInhibit    = inhibitReg;
  assign selfIdLinkActive = selfIdLinkReg;
  assign selfIdContender  = contenderReg;
  assign selfIdPowerClass = pwrClassReg;
endmodule : phy_core_base_registers
`default_nettype wire

/* File: sim/phy_core_base_registers_properties.sv */
// concurrent checks on the ports of the phy base register bank
`default_nettype none
module phy_core_base_registers_properties (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        nodeIdLoad,
  input wire logic [5:0]  nodeIdIn,
  input wire logic        linkPowerActive,
  input wire logic        forceRoot,
  input wire logic        busResetDrive,
  input wire logic [5:0]  gapCount,
  input wire logic        linkTxInhibit,
  input wire logic        selfIdLinkActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic        setup;
  logic        wrCtrl;
  logic [10:0] hiCount_reg;
  logic [10:0] hiCount_next;
  assign setup  = psel && !penable;
  assign wrCtrl = setup && pwrite && paddr == 12'h004 && pstrb[0];
  // counts how long the bus reset line has stood high so far
  always_comb hiCount_next = busResetDrive ? hiCount_reg + 11'h1 : 11'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hiCount_reg <= 11'h0;
    else hiCount_reg <= hiCount_next;
  end
  a_ready_next: assert property (setup |=> pready)
    else $error("pready missing after setup");
  a_ready_only: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_unmapped_err: assert property (setup && paddr > 12'h010 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_map_const: assert property (setup && !pwrite && paddr == 12'h008 |=> prdata == 32'h000000e3)
    else $error("map type and port count wrong");
  a_ctrl_cause: assert property ($changed(gapCount) || $changed(forceRoot) |-> $past(wrCtrl) || $past(wrCtrl, 2))
    else $error("gap count or hold-off changed without a write");
  a_inhibit_set: assert property (nodeIdLoad && nodeIdIn == 6'h3f |=> ##1 linkTxInhibit)
    else $error("identity 63 did not inhibit link");
  a_inhibit_clr: assert property (nodeIdLoad && nodeIdIn != 6'h3f |=> ##1 !linkTxInhibit)
    else $error("link inhibited for valid identity");
  a_link_and: assert property (selfIdLinkActive |-> $past(linkPowerActive))
    else $error("link active bit without link power");
  a_reset_start: assert property (wrCtrl && pwdata[6] && !busResetDrive |-> ##[3:4] busResetDrive)
    else $error("bus reset request did not start reset");
  a_reset_len: assert property ($fell(busResetDrive) |-> hiCount_reg == 11'h67c)
    else $error("bus reset length wrong");
endmodule : phy_core_base_registers_properties
bind phy_core_base_registers phy_core_base_registers_properties phy_core_base_registers_properties_i (
  .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
  .nodeIdLoad, .nodeIdIn, .linkPowerActive, .forceRoot, .busResetDrive, .gapCount, .linkTxInhibit,
  .selfIdLinkActive
);
`default_nettype wire

/* File: sim/link_layer_model.sv */
// link layer model: apb master towards the phy registers and packet gate
`default_nettype none
module link_layer_model (
  input wire logic         clk,
  output var logic         psel,
  output var logic         penable,
  output var logic         pwrite,
  output var logic [11:0]  paddr,
  output var logic [31:0]  pwdata,
  output var logic [3:0]   pstrb,
  input wire logic         pready,
  input wire logic [31:0]  prdata,
  input wire logic         pslverr,
  input wire logic         linkTxInhibit
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  // entered just after a rising edge; leaves one idle edge so calls never collide
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // only the bench watchdog ends a wait for pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  // a misconfigured bus forbids any transmission
  task automatic sendPacket(output logic sent);
    sent = !linkTxInhibit;
  endtask : sendPacket
endmodule : link_layer_model
`default_nettype wire

/* File: sim/phy_core_base_registers_test.sv */
// self-checking bench of the phy base register bank
`default_nettype none
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module phy_core_base_registers_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, nodeIdLoad, rootIn, cablePowerOk;
  logic        linkPowerActive, contenderStrap, forceRoot, busResetDrive, linkTxInhibit;
  logic        selfIdLinkActive, selfIdContender, err, sent;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [5:0]  nodeIdIn, gapCount;
  logic [2:0]  powerClassStrap, selfIdPowerClass;
  int          nErrors = 0;
  int          checkCount = 0;
  int          cycleCount = 0;
  always @(posedge clk) cycleCount <= cycleCount + 1;
  phy_core_base_registers phy_core_base_registers_i (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
    .nodeIdLoad, .nodeIdIn, .rootIn, .cablePowerOk, .linkPowerActive, .contenderStrap, .powerClassStrap,
    .forceRoot, .busResetDrive, .gapCount, .linkTxInhibit, .selfIdLinkActive, .selfIdContender,
    .selfIdPowerClass
  );
  link_layer_model link_layer_model_i (
    .clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .linkTxInhibit
  );
  task check(input string n, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      nErrors++;
    end
  endtask : check
  task giveVerdict;
    if (nErrors == 0 && checkCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : giveVerdict
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf);
    link_layer_model_i.xfer(1'b1, a, d, s, rd, err);
  endtask : wr
  task rdChk(input string n, input logic [11:0] a, input logic [7:0] e);
    link_layer_model_i.xfer(1'b0, a, 8'h0, 4'h0, rd, err);
    check(n, {24'h0, e}, rd);
    check("readErr", 32'h0, {31'h0, err});
  endtask : rdChk
  task loadId(input logic [5:0] id);
    nodeIdIn <= id;
    nodeIdLoad <= 1'b1;
    @(posedge clk);
    nodeIdLoad <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : loadId
  task testResetValues;
    rdChk("reg0", 12'h000, 8'h01);
    rdChk("reg1", 12'h004, 8'h3f);
    rdChk("reg2", 12'h008, 8'he3);
    rdChk("reg3", 12'h00c, 8'h40);
    rdChk("reg4", 12'h010, 8'hc5);
    `CHK("gapCount", 6'h3f, gapCount);
    `CHK("forceRoot", 1'b0, forceRoot);
    `CHK("contender", 1'b1, selfIdContender);
    `CHK("powerClass", 3'h5, selfIdPowerClass);
    `CHK("linkActive", 1'b1, selfIdLinkActive);
  endtask : testResetValues
  task testReadOnly;
    logic [11:0] a[3] = '{12'h000, 12'h008, 12'h00c};
    logic [7:0]  e[3] = '{8'h01, 8'he3, 8'h40};
    logic [11:0] bad[3] = '{12'h014, 12'h002, 12'h100};
    for (int i = 0; i < 3; i++) begin
      wr(a[i], 8'hff);
      rdChk("roReg", a[i], e[i]);
      link_layer_model_i.xfer(1'b0, bad[i], 8'h0, 4'h0, rd, err);
      `CHK("unmappedErr", 1'b1, err);
      `CHK("unmappedData", 32'h0, rd);
    end
  endtask : testReadOnly
  task testStatus;
    rootIn <= 1'b1;
    cablePowerOk <= 1'b0;
    loadId(6'h2a);
    rdChk("reg0", 12'h000, 8'haa);
    loadId(6'h3f);
    `CHK("inhibit", 1'b1, linkTxInhibit);
    link_layer_model_i.sendPacket(sent);
    `CHK("packetSent", 1'b0, sent);
    loadId(6'h3e);
    `CHK("inhibit", 1'b0, linkTxInhibit);
    rdChk("reg0", 12'h000, 8'hfa);
  endtask : testStatus
  task testControl;
    wr(12'h004, 8'h85);
    rdChk("reg1", 12'h004, 8'h85);
    `CHK("forceRoot", 1'b1, forceRoot);
    `CHK("gapCount", 6'h05, gapCount);
    wr(12'h004, 8'h00, 4'h0);
    `CHK("gapCount", 6'h05, gapCount);
    wr(12'h010, 8'h3a);
    rdChk("reg4", 12'h010, 8'h02);
    `CHK("linkActive", 1'b0, selfIdLinkActive);
    `CHK("contender", 1'b0, selfIdContender);
    `CHK("powerClass", 3'h2, selfIdPowerClass);
    wr(12'h010, 8'h80);
    linkPowerActive <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("linkActive", 1'b0, selfIdLinkActive);
    linkPowerActive <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("linkActive", 1'b1, selfIdLinkActive);
    wr(12'h004, 8'h05);
    `CHK("forceRoot", 1'b0, forceRoot);
  endtask : testControl
  task testBusReset;
    int n;
    int t0;
    wr(12'h004, 8'h45);
    n = 0;
    while (busResetDrive !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    `CHK("resetStarted", 1'b1, busResetDrive);
    t0 = cycleCount;
    // a second request mid-reset must not stretch the reset
    wr(12'h004, 8'h45);
    while (busResetDrive === 1'b1 && cycleCount - t0 < 3000) begin
      @(posedge clk);
    end
    `CHK("resetCycles", 32'h67c, cycleCount - t0);
    rdChk("reg1", 12'h004, 8'h05);
  endtask : testBusReset
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    nodeIdLoad = 1'b0;
    nodeIdIn = 6'h0;
    rootIn = 1'b0;
    cablePowerOk = 1'b1;
    linkPowerActive = 1'b1;
    contenderStrap = 1'b1;
    powerClassStrap = 3'h5;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    testResetValues;
    testReadOnly;
    testStatus;
    testControl;
    testBusReset;
    giveVerdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    nErrors++;
    giveVerdict;
  end
endmodule : phy_core_base_registers_test
`default_nettype wire
